// ---- logic/ufc_pkg.sv ----
// constants for the serial port flag clear and data register block
`default_nettype none
package ufc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_FLAG_CLEAR = 8'h20;
  localparam logic [7:0] OFF_RX_CHAR = 8'h24;
  localparam logic [7:0] OFF_TX_CHAR = 8'h28;
  // status / clear bit positions
  localparam int BIT_WAKEUP = 20;
  localparam int BIT_ADDR_MATCH = 17;
  localparam int BIT_BLOCK_END = 12;
  localparam int BIT_RX_TIMEOUT = 11;
  localparam int BIT_CTS_CHANGE = 9;
  localparam int BIT_LIN_BREAK = 8;
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_TX_COMPLETE = 6;
  localparam int BIT_RX_NOT_EMPTY = 5;
  localparam int BIT_IDLE = 4;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_NOISE = 2;
  localparam int BIT_FRAMING = 1;
  localparam int BIT_PARITY = 0;
  // clearable flags, full port and reduced port
  localparam logic [31:0] CLR_MASK_FULL = 32'h00121B5F;
  localparam logic [31:0] CLR_MASK_REDUCED = 32'h0002025F;
  // character field
  localparam int CHAR_W = 9;
  localparam int CHAR_TOP9 = 8;
  localparam int CHAR_TOP8 = 7;
  // reset values
  localparam logic [31:0] RST_FLAGS = 32'h00000000;
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_RX_NOT_EMPTY = 1'b0;
  localparam logic [8:0] RST_CHAR = 9'h000;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // bus transaction states
  typedef enum logic [1:0] {
    UFC_BUS_IDLE = 2'b01,
    UFC_BUS_RESP = 2'b10
  } ufc_bus_state_t;
endpackage : ufc_pkg
`default_nettype wire

// ---- logic/ufc_top.sv ----
// serial port status flag clear, receive data and transmit data registers
`timescale 1ns/1ps
`default_nettype none
// Function
// - writing 1 to clear bit 20 clears the wakeup flag
// - writing 1 to clear bit 17 clears the address match flag
// - writing 1 to clear bit 12 clears the block end flag
// - writing 1 to clear bit 11 clears the receiver timeout flag
// - writing 1 to clear bit 9 clears the clear-to-send change flag
// - writing 1 to clear bit 8 clears the LIN break flag
// - writing 1 to clear bit 6 clears the transmission complete flag
// - writing 1 to clear bit 4 clears the idle line flag
// - writing 1 to clear bit 3 clears the overrun flag
// - writing 1 to clear bit 2 clears the noise error flag
// - writing 1 to clear bit 1 clears the framing error flag
// - writing 1 to clear bit 0 clears the parity error flag
// - reduced port ignores wakeup, block end, timeout and LIN break clears
// - last received character reads in bits 8:0, upper bits zero
// - with parity on, received parity bit sits in bit 7 or 8
// - character to send comes from written bits 8:0, readable back
// - with parity on, written top bit is replaced by computed parity
// - reading receive data clears receive buffer not empty
// - writing transmit data clears transmit buffer empty
module ufc_top #(
  parameter int ADDR_W = 8,
  parameter bit FULL_FEATURE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] flag_set,
  input wire logic parity_enable,
  input wire logic nine_bit_data,
  input wire logic parity_odd,
  input wire logic [8:0] rx_char,
  input wire logic rx_parity_bit,
  input wire logic rx_load,
  input wire logic tx_taken,
  output logic [31:0] status_flags,
  output logic transmit_buffer_empty,
  output logic receive_buffer_not_empty,
  output logic [8:0] tx_char
);

  // refuse address widths that cannot reach the map
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ufc_top: ADDR_W must be 8 to 32");
  end

  localparam logic [31:0] CLR_MASK = FULL_FEATURE ? ufc_pkg::CLR_MASK_FULL : ufc_pkg::CLR_MASK_REDUCED;

  // protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // write channel state
  ufc_pkg::ufc_bus_state_t wr_state_r, wr_state_nxt;
  logic aw_have_r, aw_have_nxt;
  logic w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic wr_fire;
  logic wr_hit_clear, wr_hit_tx, wr_hit_any;
  logic [31:0] wmask;
  logic [31:0] waddr_wide;

  // handshake readies straight from state
  assign s_axi_awready = (wr_state_r == ufc_pkg::UFC_BUS_IDLE) && !aw_have_r;
  assign s_axi_wready = (wr_state_r == ufc_pkg::UFC_BUS_IDLE) && !w_have_r;
  assign s_axi_bvalid = (wr_state_r == ufc_pkg::UFC_BUS_RESP);
  assign s_axi_bresp = bresp_r;

  // write decode on the held address and data
  assign wr_fire = (wr_state_r == ufc_pkg::UFC_BUS_IDLE) && aw_have_r && w_have_r;
  assign waddr_wide = 32'(waddr_r); // zero-extended so the upper-bit test also works at ADDR_W of 8
  assign wr_hit_any = (waddr_wide[31:8] == 24'h000000);
  assign wr_hit_clear = wr_hit_any && (waddr_r[7:0] == ufc_pkg::OFF_FLAG_CLEAR);
  assign wr_hit_tx = wr_hit_any && (waddr_r[7:0] == ufc_pkg::OFF_TX_CHAR);
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // address and data are taken in either order, then one response
  always_comb begin
    wr_state_nxt = wr_state_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bresp_nxt = bresp_r;
    case (wr_state_r)
      ufc_pkg::UFC_BUS_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_have_nxt = 1'b1;
          waddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_have_nxt = 1'b1;
          wdata_nxt = s_axi_wdata;
          wstrb_nxt = s_axi_wstrb;
        end
        if (wr_fire) begin
          wr_state_nxt = ufc_pkg::UFC_BUS_RESP;
          aw_have_nxt = 1'b0;
          w_have_nxt = 1'b0;
          if (wr_hit_any && (waddr_r[7:0] == ufc_pkg::OFF_STATUS || wr_hit_clear ||
              waddr_r[7:0] == ufc_pkg::OFF_RX_CHAR || wr_hit_tx)) begin
            bresp_nxt = ufc_pkg::RESP_OKAY;
          end else begin
            bresp_nxt = ufc_pkg::RESP_SLVERR; // unmapped
          end
        end
      end
      ufc_pkg::UFC_BUS_RESP: begin
        if (s_axi_bready) begin
          wr_state_nxt = ufc_pkg::UFC_BUS_IDLE;
        end
      end
      default: begin
        wr_state_nxt = ufc_pkg::UFC_BUS_IDLE;
      end
    endcase
  end

  // write channel registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_state_r <= ufc_pkg::UFC_BUS_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= ufc_pkg::RESP_OKAY;
    end else begin
      wr_state_r <= wr_state_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // read channel state
  ufc_pkg::ufc_bus_state_t rd_state_r, rd_state_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic rd_take;
  logic rd_in_map;
  logic rd_rx_char;
  logic [31:0] araddr_wide;

  // read handshake and address decode
  assign s_axi_arready = (rd_state_r == ufc_pkg::UFC_BUS_IDLE);
  assign s_axi_rvalid = (rd_state_r == ufc_pkg::UFC_BUS_RESP);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign araddr_wide = 32'(s_axi_araddr); // zero-extended so the upper-bit test also works at ADDR_W of 8
  assign rd_in_map = (araddr_wide[31:8] == 24'h000000);
  assign rd_rx_char = rd_take && rd_in_map && (s_axi_araddr[7:0] == ufc_pkg::OFF_RX_CHAR);

  // core state read back by the bus
  logic [31:0] flag_r, flag_nxt;
  logic tbe_r, tbe_nxt;
  logic receive_buffer_not_empty_r, receive_buffer_not_empty_nxt;
  logic [8:0] rx_hold_r, rx_hold_nxt;
  logic [8:0] tx_hold_r, tx_hold_nxt;
  logic [8:0] tx_char_r, tx_char_nxt;
  logic [31:0] status_view;

  // status word with the buffer flags merged in
  always_comb begin
    status_view = flag_r;
    status_view[ufc_pkg::BIT_TX_EMPTY] = tbe_r;
    status_view[ufc_pkg::BIT_RX_NOT_EMPTY] = receive_buffer_not_empty_r;
  end

  // read mux sampled at the address handshake
  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rd_state_r)
      ufc_pkg::UFC_BUS_IDLE: begin
        if (rd_take) begin
          rd_state_nxt = ufc_pkg::UFC_BUS_RESP;
          rresp_nxt = ufc_pkg::RESP_OKAY;
          rdata_nxt = 32'h00000000;
          if (!rd_in_map) begin
            rresp_nxt = ufc_pkg::RESP_SLVERR;
          end else begin
            case (s_axi_araddr[7:0])
              ufc_pkg::OFF_STATUS: rdata_nxt = status_view;
              ufc_pkg::OFF_FLAG_CLEAR: rdata_nxt = 32'h00000000;
              ufc_pkg::OFF_RX_CHAR: rdata_nxt = {23'h000000, rx_hold_r};
              ufc_pkg::OFF_TX_CHAR: rdata_nxt = {23'h000000, tx_hold_r};
              default: rresp_nxt = ufc_pkg::RESP_SLVERR;
            endcase
          end
        end
      end
      ufc_pkg::UFC_BUS_RESP: begin
        if (s_axi_rready) begin
          rd_state_nxt = ufc_pkg::UFC_BUS_IDLE;
        end
      end
      default: begin
        rd_state_nxt = ufc_pkg::UFC_BUS_IDLE;
      end
    endcase
  end

  // read channel registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_state_r <= ufc_pkg::UFC_BUS_IDLE;
      rdata_r <= 32'h00000000;
      rresp_r <= ufc_pkg::RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // status flags
  logic [31:0] clr_vec;
  logic [31:0] set_vec;

  // write-one-to-clear, only on byte lanes that were strobed
  assign clr_vec = (wr_fire && wr_hit_clear) ? (wdata_r & wmask & CLR_MASK) : 32'h00000000;

  // overrun also raised when a character lands on an unread one
  always_comb begin
    set_vec = flag_set & CLR_MASK;
    set_vec[ufc_pkg::BIT_OVERRUN] = flag_set[ufc_pkg::BIT_OVERRUN] | (rx_load & receive_buffer_not_empty_r);
  end

  // one flag per bit; a set in the clearing cycle wins
  for (genvar i = 0; i < 32; i++) begin : g_flag
    always_comb begin
      flag_nxt[i] = set_vec[i] | (flag_r[i] & ~clr_vec[i]);
    end
  end

  // data registers
  logic tx_write;
  logic [8:0] rx_pack;
  logic tx_par;

  assign tx_write = wr_fire && wr_hit_tx;

  // received character with parity placed in the top data bit
  always_comb begin
    rx_pack = rx_char;
    if (!nine_bit_data) begin
      rx_pack[ufc_pkg::CHAR_TOP9] = 1'b0;
    end
    if (parity_enable) begin
      if (nine_bit_data) begin
        rx_pack[ufc_pkg::CHAR_TOP9] = rx_parity_bit;
      end else begin
        rx_pack[ufc_pkg::CHAR_TOP8] = rx_parity_bit;
      end
    end
  end

  // parity over the data bits below the top bit
  always_comb begin
    if (nine_bit_data) begin
      tx_par = (^tx_hold_r[7:0]) ^ parity_odd;
    end else begin
      tx_par = (^tx_hold_r[6:0]) ^ parity_odd;
    end
  end

  // buffer flags, held characters and outgoing character
  always_comb begin
    receive_buffer_not_empty_nxt = rx_load | (receive_buffer_not_empty_r & ~rd_rx_char);
    tbe_nxt = tx_taken | (tbe_r & ~tx_write);
    rx_hold_nxt = rx_load ? rx_pack : rx_hold_r;
    tx_hold_nxt = tx_hold_r;
    if (tx_write) begin
      if (wstrb_r[0]) begin
        tx_hold_nxt[7:0] = wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        tx_hold_nxt[8] = wdata_r[8];
      end
    end
    tx_char_nxt = tx_hold_r;
    if (!nine_bit_data) begin
      tx_char_nxt[ufc_pkg::CHAR_TOP9] = 1'b0;
    end
    if (parity_enable) begin
      if (nine_bit_data) begin
        tx_char_nxt[ufc_pkg::CHAR_TOP9] = tx_par;
      end else begin
        tx_char_nxt[ufc_pkg::CHAR_TOP8] = tx_par;
      end
    end
  end

  // core registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_r <= ufc_pkg::RST_FLAGS;
      tbe_r <= ufc_pkg::RST_TX_EMPTY;
      receive_buffer_not_empty_r <= ufc_pkg::RST_RX_NOT_EMPTY;
      rx_hold_r <= ufc_pkg::RST_CHAR;
      tx_hold_r <= ufc_pkg::RST_CHAR;
      tx_char_r <= ufc_pkg::RST_CHAR;
    end else begin
      flag_r <= flag_nxt;
      tbe_r <= tbe_nxt;
      receive_buffer_not_empty_r <= receive_buffer_not_empty_nxt;
      rx_hold_r <= rx_hold_nxt;
      tx_hold_r <= tx_hold_nxt;
      tx_char_r <= tx_char_nxt;
    end
  end

  // outputs to the framing logic
  assign status_flags = status_view;
  assign transmit_buffer_empty = tbe_r;
  assign receive_buffer_not_empty = receive_buffer_not_empty_r;
  assign tx_char = tx_char_r;

endmodule : ufc_top
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the flag clear and character registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, rst, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, parity_enable;
  logic nine_bit_data, parity_odd, rx_parity_bit, rx_load, tx_taken, transmit_buffer_empty;
  logic receive_buffer_not_empty;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, flag_set, status_flags, flags, red_flags;
  logic [8:0] rx_char, tx_char, last_tx, c, e;
  int fails, n_checks, bits[12];
  ufc_top ufc_top_inst (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .flag_set, .parity_enable, .nine_bit_data, .parity_odd, .rx_char, .rx_parity_bit, .rx_load,
    .tx_taken, .status_flags, .transmit_buffer_empty, .receive_buffer_not_empty, .tx_char);
  ufc_line_model ufc_line_model_inst (.ref_clk, .slow, .transmit_buffer_empty, .tx_char, .flag_set, .rx_char,
    .rx_parity_bit, .rx_load, .tx_taken, .last_tx);
  // reduced-feature twin on the same stimulus; only its flags are watched
  ufc_top #(.ADDR_W(8), .FULL_FEATURE(1'b0)) ufc_top_red_inst (.ref_clk, .rst, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
    .flag_set, .parity_enable, .nine_bit_data, .parity_odd, .rx_char, .rx_parity_bit, .rx_load,
    .tx_taken, .status_flags(red_flags), .transmit_buffer_empty(), .receive_buffer_not_empty(),
    .tx_char());
  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  // bus write; handshakes judged on settled values at the falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge ref_clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge ref_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    chk({30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge ref_clk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    chk(d, x);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    close_out();
  end
  initial begin
    {fails, n_checks} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, parity_enable, nine_bit_data, parity_odd, slow} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, rst, s_axi_wstrb} = 7'h7F;
    bits = '{20, 17, 12, 11, 9, 8, 6, 4, 3, 2, 1, 0};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(ufc_pkg::OFF_STATUS, 32'h00000080, ufc_pkg::RESP_OKAY);
    rd(ufc_pkg::OFF_FLAG_CLEAR, 32'h00000000, ufc_pkg::RESP_OKAY);
    rd(8'h30, 32'h00000000, ufc_pkg::RESP_SLVERR);
    wr(8'h30, 32'h00000001, ufc_pkg::RESP_SLVERR);
    $display("test reset done");
    // every clear bit drops its own flag only
    flags = ufc_pkg::CLR_MASK_FULL;
    ufc_line_model_inst.raise(flags);
    wr(ufc_pkg::OFF_FLAG_CLEAR, 32'h00000000, ufc_pkg::RESP_OKAY);
    @(negedge ref_clk);
    chk(red_flags, ufc_pkg::CLR_MASK_REDUCED | 32'h00000080);
    @(posedge ref_clk);
    foreach (bits[i]) begin
      wr(ufc_pkg::OFF_FLAG_CLEAR, 32'h00000001 << bits[i], ufc_pkg::RESP_OKAY);
      flags[bits[i]] = 1'b0;
      rd(ufc_pkg::OFF_STATUS, flags | 32'h00000080, ufc_pkg::RESP_OKAY);
    end
    @(negedge ref_clk);
    chk(red_flags, 32'h00000080);
    @(posedge ref_clk);
    $display("test clear done");
    // received characters in every length and parity mode, one overrun
    for (int i = 0; i < 4; i++) begin
      {parity_enable, nine_bit_data} <= i[1:0];
      c = 9'h15A ^ i[8:0];
      e = i[0] ? {i[1] ? ~c[0] : c[8], c[7:0]} : {1'b0, i[1] ? ~c[0] : c[7], c[6:0]};
      ufc_line_model_inst.send_rx(c, ~c[0]);
      if (i == 3) begin
        @(posedge ref_clk);
        ufc_line_model_inst.send_rx(c, ~c[0]);
      end
      rd(ufc_pkg::OFF_STATUS, (i == 3) ? 32'h000000A8 : 32'h000000A0, ufc_pkg::RESP_OKAY);
      rd(ufc_pkg::OFF_RX_CHAR, {23'h0, e}, ufc_pkg::RESP_OKAY);
      rd(ufc_pkg::OFF_STATUS, (i == 3) ? 32'h00000088 : 32'h00000080, ufc_pkg::RESP_OKAY);
    end
    wr(ufc_pkg::OFF_FLAG_CLEAR, 32'h00000008, ufc_pkg::RESP_OKAY);
    $display("test receive done");
    // transmit in every mode, prompt and slow shift register
    for (int i = 0; i < 4; i++) begin
      {parity_enable, nine_bit_data, parity_odd, slow} <= {i[1:0], ^i[1:0], i != 0};
      c = 9'h1C3 + i[8:0];
      e = i[0] ? {i[1] ? ^{c[7:0], ^i[1:0]} : c[8], c[7:0]} : {1'b0, i[1] ? ^{c[6:0], ^i[1:0]} : c[7], c[6:0]};
      wait (transmit_buffer_empty === 1'b1);
      @(posedge ref_clk);
      wr(ufc_pkg::OFF_TX_CHAR, {23'h0, c}, ufc_pkg::RESP_OKAY);
      if (i != 0) rd(ufc_pkg::OFF_STATUS, 32'h00000000, ufc_pkg::RESP_OKAY);
      rd(ufc_pkg::OFF_TX_CHAR, {23'h0, c}, ufc_pkg::RESP_OKAY);
      wait (transmit_buffer_empty === 1'b1);
      @(posedge ref_clk);
      chk({23'h0, last_tx}, {23'h0, e});
    end
    $display("test transmit done");
    close_out();
  end
endmodule : testbench
`default_nettype wire

// ---- tb/ufc_line_model.sv ----
// serial line side: receive events, flag events, transmit shift register
`timescale 1ns/1ps
`default_nettype none
module ufc_line_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic transmit_buffer_empty,
  input wire logic [8:0] tx_char,
  output logic [31:0] flag_set,
  output logic [8:0] rx_char,
  output logic rx_parity_bit,
  output logic rx_load,
  output logic tx_taken,
  output logic [8:0] last_tx
);
  int wait_n;
  initial begin
    {flag_set, rx_char, rx_parity_bit, rx_load, tx_taken, last_tx} = '0;
    wait_n = 0;
  end
  // one received character; lines show the inverse once it is gone
  task automatic send_rx(input logic [8:0] c, input logic p);
    rx_char <= c;
    rx_parity_bit <= p;
    rx_load <= 1'b1;
    @(posedge ref_clk);
    rx_load <= 1'b0;
    rx_char <= ~c;
    rx_parity_bit <= ~p;
  endtask : send_rx
  // one-cycle flag set events
  task automatic raise(input logic [31:0] m);
    flag_set <= m;
    @(posedge ref_clk);
    flag_set <= 32'h00000000;
  endtask : raise
  // shift register takes the held character after a short or long pause
  always @(posedge ref_clk) begin
    tx_taken <= 1'b0;
    if (!transmit_buffer_empty && !tx_taken) begin
      wait_n <= wait_n + 1;
      if (wait_n == (slow ? 20 : 2)) begin
        last_tx <= tx_char;
        tx_taken <= 1'b1;
        wait_n <= 0;
      end
    end
  end
endmodule : ufc_line_model
`default_nettype wire

// ---- tb/ufc_properties.sv ----
// port checker for the flag clear and character registers
`timescale 1ns/1ps
`default_nettype none
module ufc_properties #(
  parameter int ADDR_W = 8,
  parameter bit FULL_FEATURE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [31:0] flag_set,
  input wire logic parity_enable,
  input wire logic nine_bit_data,
  input wire logic parity_odd,
  input wire logic rx_load,
  input wire logic tx_taken,
  input wire logic [31:0] status_flags,
  input wire logic transmit_buffer_empty,
  input wire logic receive_buffer_not_empty,
  input wire logic [8:0] tx_char
);
  localparam logic [31:0] MSK = FULL_FEATURE ? ufc_pkg::CLR_MASK_FULL : ufc_pkg::CLR_MASK_REDUCED;
  logic [ADDR_W-1:0] aw_r, aw_nxt;
  logic [31:0] w_r, w_nxt;
  // keep the last address and data taken on the write bus
  always_comb begin
    aw_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_r;
    w_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_r;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_r <= '0;
      w_r <= '0;
    end else begin
      aw_r <= aw_nxt;
      w_r <= w_nxt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_clear_ones_drop: assert property ($rose(s_axi_bvalid) && aw_r == ufc_pkg::OFF_FLAG_CLEAR
    |-> (status_flags & w_r & MSK & ~$past(flag_set)) == 32'h00000000) else $error("flag survived its clear");
  a_zero_keeps_flag: assert property ($rose(s_axi_bvalid) && aw_r == ufc_pkg::OFF_FLAG_CLEAR
    |-> (status_flags & ~w_r & MSK) == (($past(status_flags) | $past(flag_set)
    | {28'h0000000, $past(rx_load && receive_buffer_not_empty), 3'h0}) & ~w_r & MSK)) else $error("flag changed");
  a_tx_write_busy: assert property ($rose(s_axi_bvalid) && aw_r == ufc_pkg::OFF_TX_CHAR && !$past(tx_taken)
    |-> !transmit_buffer_empty) else $error("transmit empty stayed set");
  a_rx_read_empty: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ufc_pkg::OFF_RX_CHAR
    && !rx_load |=> !receive_buffer_not_empty) else $error("receive not empty stayed set");
  a_rx_upper_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ufc_pkg::OFF_RX_CHAR
    |=> s_axi_rvalid && s_axi_rdata[31:9] == 23'h000000) else $error("receive word upper bits");
  a_rx_load_full: assert property (rx_load |=> receive_buffer_not_empty) else $error("no receive flag");
  a_tx_parity_top: assert property ($rose(s_axi_bvalid) && aw_r == ufc_pkg::OFF_TX_CHAR && parity_enable
    |=> (nine_bit_data ? tx_char[8] == ^{tx_char[7:0], parity_odd} : tx_char[7] == ^{tx_char[6:0], parity_odd}))
    else $error("transmit parity wrong");
  a_tx_plain_char: assert property ($rose(s_axi_bvalid) && aw_r == ufc_pkg::OFF_TX_CHAR && !parity_enable
    |=> tx_char == (nine_bit_data ? w_r[8:0] : {1'b0, w_r[7:0]})) else $error("transmit character wrong");
endmodule : ufc_properties
bind ufc_top ufc_properties #(.ADDR_W(ADDR_W), .FULL_FEATURE(FULL_FEATURE)) ufc_properties_inst (.*);
`default_nettype wire
